// >>> rtl/msfs_pkg.sv
// Constants, field layouts and reset values of the multi-speed frequency select block.
// Assumes a 32-bit APB with byte addresses and one aligned word for each register.
package msfs_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_VTERM = 8'h04;
  localparam logic [7:0] OFF_TFUNC = 8'h08;
  localparam logic [7:0] OFF_BOOST1 = 8'h0C;
  localparam logic [7:0] OFF_BOOST2 = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_BOOST_OUT = 8'h18;
  localparam logic [7:0] OFF_PRESET = 8'h40;
  localparam logic [7:0] OFF_PRESET_LAST = 8'h78;

  // Control register field positions.
  localparam int CTRL_LOAD_LSB = 0;
  localparam int CTRL_FLUX_LSB = 4;
  localparam int CTRL_REMOTE_LSB = 8;
  localparam int CTRL_PWS_LSB = 12;
  localparam int CTRL_UGRP_BIT = 14;
  localparam int CTRL_PANEL_BIT = 15;

  // Status register field positions.
  localparam int STAT_INDEX_LSB = 16;
  localparam int STAT_VALID_BIT = 20;
  localparam int STAT_SECOND_BIT = 21;

  // Frequencies in 0.1 Hz steps; boosts in 0.1 percent steps.
  localparam int PRESET_W = 16;
  localparam int NUM_PRESETS = 15;
  localparam int NUM_TERMS = 5;
  localparam logic [15:0] FREQ_MAX = 16'h0FA0;
  localparam logic [15:0] NOT_SELECTED = 16'h270F;
  localparam logic [15:0] RST_HIGH = 16'h0258;
  localparam logic [15:0] RST_MID = 16'h012C;
  localparam logic [15:0] RST_LOW = 16'h0064;
  localparam logic [15:0] BOOST_MAX = 16'h012C;
  localparam logic [15:0] RST_BOOST1 = 16'h003C;
  localparam logic [15:0] RST_BOOST2 = 16'h0000;

  // Virtual terminal function codes.
  localparam logic [3:0] FN_LOW = 4'h0;
  localparam logic [3:0] FN_MID = 4'h1;
  localparam logic [3:0] FN_HIGH = 4'h2;
  localparam logic [3:0] FN_SECOND = 4'h3;
  localparam logic [3:0] FN_EXT = 4'h8;
  localparam logic [19:0] RST_TFUNC = 20'h8_3210;
  localparam logic [4:0] RST_VTERM = 5'h00;

  // Speed numbers; preset array slot is speed number minus one.
  localparam logic [3:0] SPD_NONE = 4'h0;
  localparam logic [3:0] SPD_HIGH = 4'h1;
  localparam logic [3:0] SPD_MID = 4'h2;
  localparam logic [3:0] SPD_LOW = 4'h3;
  localparam logic [3:0] SPD_FIRST_EXT = 4'h4;

  typedef enum logic [1:0] {
    MSFS_LP_CONST = 2'b00,
    MSFS_LP_VARIABLE = 2'b01,
    MSFS_LP_LIFT_FWD = 2'b10,
    MSFS_LP_LIFT_REV = 2'b11
  } msfs_load_e;

endpackage : msfs_pkg

// >>> rtl/msfs_sel_if.sv
// Carrier between the top block and the speed decoder.
// Assumes both ends run on the same clock; the decoder is purely combinational.
`timescale 1ns/10ps
interface msfs_sel_if;
  logic high_speed_select;
  logic middle_speed_select;
  logic low_speed_select;
  logic extended_speed_select;
  logic [msfs_pkg::PRESET_W-1:0] preset [msfs_pkg::NUM_PRESETS];
  logic [3:0] speed;
  logic [msfs_pkg::PRESET_W-1:0] freq;

  modport ctrl (
    output high_speed_select, middle_speed_select, low_speed_select, extended_speed_select, preset,
    input speed, freq
  );
  modport dec (
    input high_speed_select, middle_speed_select, low_speed_select, extended_speed_select, preset,
    output speed, freq
  );
endinterface : msfs_sel_if

// >>> rtl/msfs_decoder.sv
// Combinational multi-speed decoder: four speed inputs and fifteen presets to a speed and a frequency.
// Assumes the presets hold only legal values, which the register file guarantees.
`timescale 1ns/10ps
module msfs_decoder (
  // Selection and result
  msfs_sel_if.dec sel
);

  function automatic logic [3:0] msfs_combo(input logic [3:0] code);
    logic [3:0] spd;
    spd = msfs_pkg::SPD_NONE;
    unique case (code)
      4'b0000: spd = msfs_pkg::SPD_NONE;
      4'b0001: spd = msfs_pkg::SPD_LOW;
      4'b0010: spd = msfs_pkg::SPD_MID;
      4'b0100: spd = msfs_pkg::SPD_HIGH;
      4'b0011: spd = 4'h4;
      4'b0101: spd = 4'h5;
      4'b0110: spd = 4'h6;
      4'b0111: spd = 4'h7;
      4'b1000: spd = 4'h8;
      4'b1001: spd = 4'h9;
      4'b1010: spd = 4'hA;
      4'b1011: spd = 4'hB;
      4'b1100: spd = 4'hC;
      4'b1101: spd = 4'hD;
      4'b1110: spd = 4'hE;
      4'b1111: spd = 4'hF;
    endcase
    return spd;
  endfunction : msfs_combo

  logic [3:0] code;
  logic [3:0] combo;
  logic [3:0] pick;

  assign code = {sel.extended_speed_select, sel.high_speed_select, sel.middle_speed_select, sel.low_speed_select};

  always_comb begin
    combo = msfs_combo(code);
    pick = combo;
    // An unset combination preset falls back on the three-speed priority, so a half-configured table stays usable.
    if (combo >= msfs_pkg::SPD_FIRST_EXT && sel.preset[combo - 4'h1] == msfs_pkg::NOT_SELECTED) begin
      if (code == 4'b1000) begin
        pick = msfs_pkg::SPD_LOW;
      end else if (sel.low_speed_select) begin
        pick = msfs_pkg::SPD_LOW;
      end else if (sel.middle_speed_select) begin
        pick = msfs_pkg::SPD_MID;
      end else begin
        pick = msfs_pkg::SPD_HIGH;
      end
    end
  end

  assign sel.speed = pick;
  assign sel.freq = (pick == msfs_pkg::SPD_NONE) ? '0 : sel.preset[pick - 4'h1];

endmodule : msfs_decoder

// >>> rtl/msfs_top.sv
// Multi-speed frequency select with lift-type torque boost, behind an APB register file.
// Assumes an APB master on pclk; run_reverse arrives asynchronously from the drive's direction logic.
`timescale 1ns/10ps

module msfs_top #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Drive direction
  input wire logic run_reverse,
  // Drive commands
  output logic [15:0] target_freq,
  output logic [3:0] speed_index,
  output logic freq_valid,
  output logic [15:0] torque_boost,
  output logic second_function_en,
  output logic remote_up,
  output logic remote_down,
  output logic remote_clear
);

  function automatic logic msfs_route(input logic [4:0] term, input logic [19:0] func, input logic [3:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < msfs_pkg::NUM_TERMS; i++) begin
      hit = hit | (term[i] & (func[4*i +: 4] == code));
    end
    return hit;
  endfunction : msfs_route

  msfs_sel_if sel ();

  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic [1:0] load_pattern_reg;
  logic [1:0] flux_mode_reg;
  logic [1:0] remote_sel_reg;
  logic [1:0] param_write_sel_reg;
  logic user_group_reg;
  logic panel_mode_reg;
  logic [4:0] vterm_reg;
  logic [19:0] tfunc_reg;
  logic [15:0] boost1_reg;
  logic [15:0] boost2_reg;
  logic [15:0] preset_reg [msfs_pkg::NUM_PRESETS];
  logic rev_meta_reg;
  logic rev_sync_reg;
  logic [15:0] target_freq_reg;
  logic [3:0] speed_index_reg;
  logic freq_valid_reg;
  logic [15:0] torque_boost_reg;
  logic second_reg;
  logic remote_up_reg;
  logic remote_down_reg;
  logic remote_clear_reg;

  logic [7:0] addr;
  logic wr_en;
  logic rd_take;
  logic preset_hit;
  logic [3:0] preset_slot;
  logic ext_denied;
  logic mapped;
  logic [31:0] rd_next;
  logic [15:0] wval;
  logic second_sel;
  logic [15:0] boost_sel;
  logic [15:0] boost_next;

  assign addr = 8'(paddr);
  assign wval = pwdata[15:0];
  assign wr_en = psel & penable & pready_reg & pwrite;
  assign rd_take = psel & penable & ~pready_reg;
  assign preset_hit = (addr >= msfs_pkg::OFF_PRESET) && (addr <= msfs_pkg::OFF_PRESET_LAST) && (addr[1:0] == 2'b00);
  assign preset_slot = 4'((addr - msfs_pkg::OFF_PRESET) >> 2);
  assign ext_denied = user_group_reg && ((preset_hit && preset_slot >= 4'h3) || addr == msfs_pkg::OFF_BOOST2);

  always_comb begin
    mapped = 1'b1;
    rd_next = 32'h0000_0000;
    unique case (addr)
      msfs_pkg::OFF_CTRL: begin
        rd_next[msfs_pkg::CTRL_LOAD_LSB +: 2] = load_pattern_reg;
        rd_next[msfs_pkg::CTRL_FLUX_LSB +: 2] = flux_mode_reg;
        rd_next[msfs_pkg::CTRL_REMOTE_LSB +: 2] = remote_sel_reg;
        rd_next[msfs_pkg::CTRL_PWS_LSB +: 2] = param_write_sel_reg;
        rd_next[msfs_pkg::CTRL_UGRP_BIT] = user_group_reg;
        rd_next[msfs_pkg::CTRL_PANEL_BIT] = panel_mode_reg;
      end
      msfs_pkg::OFF_VTERM: rd_next[4:0] = vterm_reg;
      msfs_pkg::OFF_TFUNC: rd_next[19:0] = tfunc_reg;
      msfs_pkg::OFF_BOOST1: rd_next[15:0] = boost1_reg;
      msfs_pkg::OFF_BOOST2: rd_next[15:0] = ext_denied ? 16'h0000 : boost2_reg;
      msfs_pkg::OFF_STATUS: begin
        rd_next[15:0] = target_freq_reg;
        rd_next[msfs_pkg::STAT_INDEX_LSB +: 4] = speed_index_reg;
        rd_next[msfs_pkg::STAT_VALID_BIT] = freq_valid_reg;
        rd_next[msfs_pkg::STAT_SECOND_BIT] = second_reg;
      end
      msfs_pkg::OFF_BOOST_OUT: rd_next[15:0] = torque_boost_reg;
      default: begin
        mapped = preset_hit;
        if (preset_hit && !ext_denied) begin
          rd_next[15:0] = preset_reg[preset_slot];
        end
      end
    endcase
  end

  // One wait state: read data and pready come from flip-flops, and writes land on the pready edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= rd_take;
      if (rd_take) begin
        pslverr_reg <= ~mapped | ext_denied;
        prdata_reg <= pwrite ? 32'h0000_0000 : rd_next;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_pattern_reg <= msfs_pkg::MSFS_LP_CONST;
      flux_mode_reg <= 2'h0;
      remote_sel_reg <= 2'h0;
      param_write_sel_reg <= 2'h0;
      user_group_reg <= 1'b0;
      panel_mode_reg <= 1'b0;
      vterm_reg <= msfs_pkg::RST_VTERM;
      tfunc_reg <= msfs_pkg::RST_TFUNC;
    end else if (wr_en) begin
      if (addr == msfs_pkg::OFF_CTRL) begin
        load_pattern_reg <= pwdata[msfs_pkg::CTRL_LOAD_LSB +: 2];
        flux_mode_reg <= pwdata[msfs_pkg::CTRL_FLUX_LSB +: 2];
        remote_sel_reg <= pwdata[msfs_pkg::CTRL_REMOTE_LSB +: 2];
        param_write_sel_reg <= pwdata[msfs_pkg::CTRL_PWS_LSB +: 2];
        user_group_reg <= pwdata[msfs_pkg::CTRL_UGRP_BIT];
        panel_mode_reg <= pwdata[msfs_pkg::CTRL_PANEL_BIT];
      end
      if (addr == msfs_pkg::OFF_VTERM) begin
        vterm_reg <= pwdata[4:0];
      end
      if (addr == msfs_pkg::OFF_TFUNC) begin
        tfunc_reg <= pwdata[19:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boost1_reg <= msfs_pkg::RST_BOOST1;
      boost2_reg <= msfs_pkg::RST_BOOST2;
    end else if (wr_en && wval <= msfs_pkg::BOOST_MAX) begin
      if (addr == msfs_pkg::OFF_BOOST1) begin
        boost1_reg <= wval;
      end
      if (addr == msfs_pkg::OFF_BOOST2 && !ext_denied) begin
        boost2_reg <= wval;
      end
    end
  end

  // Preset writes deliberately ignore the parameter write selection and the operation mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      preset_reg[0] <= msfs_pkg::RST_HIGH;
      preset_reg[1] <= msfs_pkg::RST_MID;
      preset_reg[2] <= msfs_pkg::RST_LOW;
      for (int i = 3; i < msfs_pkg::NUM_PRESETS; i++) begin
        preset_reg[i] <= msfs_pkg::NOT_SELECTED;
      end
    end else if (wr_en && preset_hit && !ext_denied) begin
      if (wval <= msfs_pkg::FREQ_MAX || (preset_slot >= 4'h3 && wval == msfs_pkg::NOT_SELECTED)) begin
        preset_reg[preset_slot] <= wval;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rev_meta_reg <= 1'b0;
      rev_sync_reg <= 1'b0;
    end else begin
      rev_meta_reg <= run_reverse;
      rev_sync_reg <= rev_meta_reg;
    end
  end

  assign sel.low_speed_select = msfs_route(vterm_reg, tfunc_reg, msfs_pkg::FN_LOW);
  assign sel.middle_speed_select = msfs_route(vterm_reg, tfunc_reg, msfs_pkg::FN_MID);
  assign sel.high_speed_select = msfs_route(vterm_reg, tfunc_reg, msfs_pkg::FN_HIGH);
  assign sel.extended_speed_select = msfs_route(vterm_reg, tfunc_reg, msfs_pkg::FN_EXT);
  assign second_sel = msfs_route(vterm_reg, tfunc_reg, msfs_pkg::FN_SECOND);

  for (genvar g = 0; g < msfs_pkg::NUM_PRESETS; g++) begin : g_preset
    assign sel.preset[g] = preset_reg[g];
  end

  msfs_decoder u_decoder (
    .sel(sel)
  );

  always_comb begin
    boost_sel = second_sel ? boost2_reg : boost1_reg;
    boost_next = boost_sel;
    if (flux_mode_reg == 2'h0) begin
      if (load_pattern_reg == msfs_pkg::MSFS_LP_LIFT_FWD && rev_sync_reg) begin
        boost_next = 16'h0000;
      end else if (load_pattern_reg == msfs_pkg::MSFS_LP_LIFT_REV && !rev_sync_reg) begin
        boost_next = 16'h0000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target_freq_reg <= 16'h0000;
      speed_index_reg <= msfs_pkg::SPD_NONE;
      freq_valid_reg <= 1'b0;
    end else if (remote_sel_reg != 2'h0) begin
      target_freq_reg <= 16'h0000;
      speed_index_reg <= msfs_pkg::SPD_NONE;
      freq_valid_reg <= 1'b0;
    end else begin
      target_freq_reg <= sel.freq;
      speed_index_reg <= sel.speed;
      freq_valid_reg <= (sel.speed != msfs_pkg::SPD_NONE);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      torque_boost_reg <= 16'h0000;
      second_reg <= 1'b0;
      remote_up_reg <= 1'b0;
      remote_down_reg <= 1'b0;
      remote_clear_reg <= 1'b0;
    end else begin
      torque_boost_reg <= boost_next;
      second_reg <= second_sel;
      remote_up_reg <= (remote_sel_reg != 2'h0) & sel.high_speed_select;
      remote_down_reg <= (remote_sel_reg != 2'h0) & sel.middle_speed_select;
      remote_clear_reg <= (remote_sel_reg != 2'h0) & sel.low_speed_select;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign target_freq = target_freq_reg;
  assign speed_index = speed_index_reg;
  assign freq_valid = freq_valid_reg;
  assign torque_boost = torque_boost_reg;
  assign second_function_en = second_reg;
  assign remote_up = remote_up_reg;
  assign remote_down = remote_down_reg;
  assign remote_clear = remote_clear_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_lift_fwd_rev;
    (load_pattern_reg == msfs_pkg::MSFS_LP_LIFT_FWD && flux_mode_reg == 2'h0 && rev_sync_reg) |=> torque_boost == 16'h0000;
  endproperty
  a_lift_fwd_rev: assert property (p_lift_fwd_rev) else $error("reverse boost not zero in lift forward pattern");

  property p_lift_fwd_fwd;
    (load_pattern_reg == msfs_pkg::MSFS_LP_LIFT_FWD && flux_mode_reg == 2'h0 && !rev_sync_reg && !second_sel)
      |=> torque_boost == $past(boost1_reg);
  endproperty
  a_lift_fwd_fwd: assert property (p_lift_fwd_fwd) else $error("forward boost lost in lift forward pattern");

  property p_lift_rev;
    (load_pattern_reg == msfs_pkg::MSFS_LP_LIFT_REV && flux_mode_reg == 2'h0)
      |=> torque_boost == ($past(rev_sync_reg) ? $past(boost_sel) : 16'h0000);
  endproperty
  a_lift_rev: assert property (p_lift_rev) else $error("wrong boost in lift reverse pattern");

  property p_second_boost;
    (second_sel && load_pattern_reg == msfs_pkg::MSFS_LP_CONST) |=> torque_boost == $past(boost2_reg) && second_function_en;
  endproperty
  a_second_boost: assert property (p_second_boost) else $error("second boost not applied");

  property p_second_route;
    (vterm_reg[3] && tfunc_reg[15:12] == msfs_pkg::FN_SECOND) |=> second_function_en;
  endproperty
  a_second_route: assert property (p_second_route) else $error("second function not routed from terminal");

  property p_flux_ignore;
    (flux_mode_reg != 2'h0) |=> torque_boost == $past(boost_sel);
  endproperty
  a_flux_ignore: assert property (p_flux_ignore) else $error("load pattern acted under flux vector control");

  property p_low_wins;
    (remote_sel_reg == 2'h0 && sel.low_speed_select && sel.high_speed_select && !sel.middle_speed_select
      && !sel.extended_speed_select && preset_reg[4] == msfs_pkg::NOT_SELECTED) |=> target_freq == $past(preset_reg[2]);
  endproperty
  a_low_wins: assert property (p_low_wins) else $error("low speed did not win over high speed");

  property p_ext_alone;
    (remote_sel_reg == 2'h0 && sel.extended_speed_select && !sel.high_speed_select && !sel.middle_speed_select
      && !sel.low_speed_select && preset_reg[7] == msfs_pkg::NOT_SELECTED)
      |=> target_freq == $past(preset_reg[2]) && speed_index == msfs_pkg::SPD_LOW;
  endproperty
  a_ext_alone: assert property (p_ext_alone) else $error("extended alone did not fall back to low speed");

  property p_remote_off;
    (remote_sel_reg != 2'h0) |=> !freq_valid && target_freq == 16'h0000;
  endproperty
  a_remote_off: assert property (p_remote_off) else $error("multi-speed active in remote mode");

  sequence s_high_setup;
    psel && !penable && pwrite && addr == (msfs_pkg::OFF_PRESET) && wval <= msfs_pkg::FREQ_MAX;
  endsequence
  sequence s_access_done;
    (psel && penable && !pready) ##1 (psel && penable && pready);
  endsequence
  property p_high_write;
    s_high_setup ##1 s_access_done |=> preset_reg[0] == $past(wval);
  endproperty
  a_high_write: assert property (p_high_write) else $error("high preset write not accepted");

  property p_ext_locked;
    (user_group_reg && rd_take && preset_hit && preset_slot >= 4'h3) |=> pslverr && prdata == 32'h0000_0000;
  endproperty
  a_ext_locked: assert property (p_ext_locked) else $error("extended preset reachable while locked");

endmodule : msfs_top

// >>> sim/msfs_apb_master.sv
// APB master model standing in for the fieldbus side that writes terminals and parameters.
// Assumes one clock shared with the slave; a hung slave is reported through the hung flag.
`timescale 1ns/10ps
module msfs_apb_master (
  // Clock
  input wire logic pclk,
  // APB request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  // APB answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e, output logic hung);
    hung = 1'b1;
    r = 32'h0000_0000;
    e = 1'b0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int i = 0; i < 64 && hung; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) begin
        hung = 1'b0;
        r = prdata;
        e = pslverr;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data is scrambled so a slave cannot lean on stale write data.
    pwdata <= ~d;
  endtask : xfer
endmodule : msfs_apb_master

// >>> sim/tb_top.sv
// Self-checking bench for the multi-speed frequency select block.
// Assumes the APB master model as far side and a bench-driven direction input.
`timescale 1ns/10ps
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, run_reverse, pready, pslverr;
  logic freq_valid, second_function_en, remote_up, remote_down, remote_clear;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] target_freq, torque_boost;
  logic [3:0] speed_index;
  logic [4:0] vt;
  int fails, n_checks, b1, b2, rem;
  int pre[15];
  int tf[5];

  msfs_top #(.ADDR_W(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .run_reverse(run_reverse), .target_freq(target_freq),
    .speed_index(speed_index), .freq_valid(freq_valid), .torque_boost(torque_boost),
    .second_function_en(second_function_en), .remote_up(remote_up), .remote_down(remote_down),
    .remote_clear(remote_clear));
  msfs_apb_master u_m (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic give_verdict();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask : chk

  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] ev,
                     input logic ee);
    logic [31:0] r;
    logic e, h;
    u_m.xfer(w, a, d, r, e, h);
    if (h) begin
      fails++;
      give_verdict();
    end else begin
      chk("pslverr", {31'h0, ee}, {31'h0, e});
      if (!w) begin
        chk("prdata", ev, r);
      end
    end
  endtask : acc

  // Reference decode of terminals, presets and mode into the expected drive outputs.
  task automatic check_out();
    logic [3:0] c;
    int n, s;
    c = 4'h0;
    s = 0;
    for (int i = 0; i < 5; i++) begin
      if (vt[i] && tf[i] < 3) c[tf[i]] = 1'b1;
      if (vt[i] && tf[i] == 3) s = 1;
      if (vt[i] && tf[i] == 8) c[3] = 1'b1;
    end
    n = (c == 4'h3) ? 4 : (c == 4'h4) ? 1 : (c == 4'h2) ? 2 : (c == 4'h1) ? 3 : c;
    if (n > 3 && pre[n - 1] == 9999) n = (c == 4'h8) ? 3 : c[0] ? 3 : c[1] ? 2 : 1;
    if (rem != 0) n = 0;
    chk("speed_index", n, {28'h0, speed_index});
    chk("target_freq", (n > 0) ? pre[n - 1] : 0, {16'h0, target_freq});
    chk("freq_valid", n > 0, {31'h0, freq_valid});
    chk("second_function_en", s, {31'h0, second_function_en});
    chk("remote", (rem != 0) ? {c[2], c[1], c[0]} : 0, {remote_up, remote_down, remote_clear});
  endtask : check_out

  task automatic run_speeds(input string nm);
    for (int v = 0; v < 32; v++) begin
      acc(1'b1, 8'h04, v, 0, 1'b0);
      vt = v[4:0];
      repeat (3) @(posedge pclk);
      #1;
      check_out();
    end
    $display("test %s done", nm);
  endtask : run_speeds

  initial begin
    fails = 0;
    n_checks = 0;
    presetn = 1'b0;
    run_reverse = 1'b0;
    vt = 5'h00;
    rem = 0;
    b1 = 60;
    b2 = 0;
    tf = '{0, 1, 2, 3, 8};
    foreach (pre[i]) pre[i] = (i > 2) ? 9999 : 300 * (2 - i) + 100 * (i / 2);
    void'($urandom(32'h0403_4846));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    foreach (pre[i]) acc(1'b0, 8'h40 + 8'(4 * i), 0, pre[i], 1'b0);
    acc(1'b0, 8'h08, 0, 32'h0008_3210, 1'b0);
    acc(1'b0, 8'h0C, 0, b1, 1'b0);
    run_speeds("default presets");
    foreach (pre[i]) begin
      pre[i] = (i == 7) ? 9999 : $urandom_range(4000);
      acc(1'b1, 8'h40 + 8'(4 * i), pre[i], 0, 1'b0);
    end
    acc(1'b1, 8'h40, 4001, 0, 1'b0);
    acc(1'b0, 8'h40, 0, pre[0], 1'b0);
    run_speeds("random presets");
    tf = '{8, 0, 1, 2, 3};
    acc(1'b1, 8'h08, 32'h0003_2108, 0, 1'b0);
    run_speeds("remapped terminals");
    rem = 1;
    acc(1'b1, 8'h00, 32'h0000_0100, 0, 1'b0);
    run_speeds("remote mode");
    tf = '{0, 1, 2, 3, 8};
    acc(1'b1, 8'h08, 32'h0008_3210, 0, 1'b0);
    b1 = $urandom_range(300);
    b2 = $urandom_range(300);
    acc(1'b1, 8'h0C, b1, 0, 1'b0);
    acc(1'b1, 8'h10, b2, 0, 1'b0);
    for (int k = 0; k < 32; k++) begin
      acc(1'b1, 8'h00, {k[4], 2'h0, k[1:0]}, 0, 1'b0);
      acc(1'b1, 8'h04, {k[3], 3'h0}, 0, 1'b0);
      run_reverse <= k[2];
      repeat (6) @(posedge pclk);
      #1;
      chk("torque_boost", (!k[4] && ((k[1:0] == 2 && k[2]) || (k[1:0] == 3 && !k[2]))) ? 0 :
          (k[3] ? b2 : b1), {16'h0, torque_boost});
    end
    $display("test boost done");
    acc(1'b1, 8'h00, 32'h0000_C000, 0, 1'b0);
    acc(1'b1, 8'h4C, 5, 0, 1'b1);
    acc(1'b0, 8'h4C, 0, 0, 1'b1);
    acc(1'b1, 8'h10, 7, 0, 1'b1);
    acc(1'b1, 8'h44, 32'h0000_0123, 0, 1'b0);
    acc(1'b0, 8'h44, 0, 32'h0000_0123, 1'b0);
    acc(1'b0, 8'h30, 0, 0, 1'b1);
    acc(1'b1, 8'h00, 0, 0, 1'b0);
    acc(1'b0, 8'h4C, 0, pre[3], 1'b0);
    acc(1'b0, 8'h10, 0, b2, 1'b0);
    $display("test lock done");
    give_verdict();
  end
endmodule : tb_top
